/* File: src/niac_pkg.sv */
package niac_pkg;
   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [9:0] IDX_FLAGS = 10'h00C;
   localparam logic [9:0] IDX_DATA_LOW = 10'h10C;
   localparam logic [9:0] IDX_ADDR_LOW = 10'h10D;
   localparam logic [9:0] IDX_DATA_HIGH = 10'h10E;
   localparam logic [9:0] IDX_ADDR_HIGH = 10'h10F;
   localparam logic [9:0] IDX_CTRL = 10'h18C;
   localparam logic [9:0] IDX_UNLOCK = 10'h18D;
   localparam logic [9:0] IDX_NONE = 10'h3FF;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int unsigned CTL_PSEL = 7;
   localparam int unsigned CTL_ABORT = 3;
   localparam int unsigned CTL_PERMIT = 2;
   localparam int unsigned CTL_WGO = 1;
   localparam int unsigned CTL_RGO = 0;
   localparam int unsigned FLAG_DONE = 7;
   // ---------------------------------------------------------------
   // Widths, keys and values
   // ---------------------------------------------------------------
   localparam int unsigned DATA_DEPTH = 256;
   localparam int unsigned DATA_HIGH_W = 6;
   localparam int unsigned ADDR_HIGH_W = 5;
   localparam int unsigned PROG_ADDR_W = 13;
   localparam int unsigned PROG_WORD_W = 14;
   localparam int unsigned SYNC_W = 4;
   localparam logic [12:0] PROG_MASK_4K = 13'h0FFF;
   localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
   localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [1:0] UNL_IDLE = 2'h0;
   localparam logic [1:0] UNL_ONE = 2'h1;
   localparam logic [1:0] UNL_TWO = 2'h2;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned WR_TIME_US = 4000;
   localparam logic [17:0] WR_CYCLES_DEF =
      18'(WR_TIME_US * 1000 / CLK_PERIOD_NS);
   // ---------------------------------------------------------------
   // Controller states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      S_IDLE = 3'h0,
      S_DRD = 3'h1,
      S_PRD1 = 3'h3,
      S_PRD2 = 3'h2,
      S_WER = 3'h6,
      S_WPR = 3'h7
   } niac_state_t;
endpackage

/* File: src/niac_mem_if.sv */
`timescale 1ns/1ps
interface niac_mem_if;
   logic wr_en;
   logic rd_en;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport ctrl (output wr_en, rd_en, addr, wdata, input rdata);
   modport mem (input wr_en, rd_en, addr, wdata, output rdata);
endinterface

/* File: src/niac_mem.sv */
`timescale 1ns/1ps
module niac_mem
   import niac_pkg::*;
(
   // Clock
   input wire logic clk,
   // Array port
   niac_mem_if.mem bus
);
   logic [7:0] array_reg [DATA_DEPTH];
   logic [7:0] rdata_reg;

   // Read data always leaves through a register
   always_ff @(posedge clk) begin
      if (bus.wr_en) begin
         array_reg[bus.addr] <= bus.wdata;
      end
      if (bus.rd_en) begin
         rdata_reg <= array_reg[bus.addr];
      end
   end

   assign bus.rdata = rdata_reg;
endmodule

/* File: src/niac_top.sv */
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
module niac_top
   import niac_pkg::*;
#(
   parameter logic [17:0] WR_CYCLES = WR_CYCLES_DEF,
   parameter logic BIG_PROG = 1'b1
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // Program array read port
   output logic [12:0] prog_addr,
   output logic prog_rd,
   input wire logic [13:0] prog_rdata,
   // Reset sources and protection strap
   input wire logic ext_reset_in,
   input wire logic wdt_reset_in,
   input wire logic bor_reset_in,
   input wire logic code_protect,
   output logic programmer_en
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   niac_mem_if mif ();
   niac_state_t state_reg, state_next;
   logic rd_ph_reg, rd_ph_next, wr_ph_reg, wr_ph_next;
   logic [9:0] idx_reg, idx_next;
   logic hready_reg, hready_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic psel_reg, psel_next, abort_reg, abort_next;
   logic permit_reg, permit_next, wgo_reg, wgo_next;
   logic rgo_reg, rgo_next, done_reg, done_next;
   logic [7:0] data_low_reg, data_low_next, addr_low_reg, addr_low_next;
   logic [5:0] data_high_reg, data_high_next;
   logic [4:0] addr_high_reg, addr_high_next;
   logic [1:0] unlock_reg, unlock_next;
   logic [17:0] cnt_reg, cnt_next;
   logic [12:0] prog_addr_reg, prog_addr_next;
   logic prog_rd_reg, prog_rd_next, prog_en_reg, prog_en_next;
   logic [3:0] sync1_reg, sync2_reg;
   logic abort_rst, busy_wr;
   logic [7:0] wd;
   logic [17:0] erase_cyc;

   niac_mem u_mem (
      .clk(hclk),
      .bus(mif.mem)
   );

   assign wd = hwdata[7:0];
   assign abort_rst = |sync2_reg[2:0];
   assign busy_wr = (state_reg == S_WER) || (state_reg == S_WPR);
   assign erase_cyc = WR_CYCLES >> 1;

   // ---------------------------------------------------------------
   // Bus slave: writes are zero-wait, reads take one wait state
   // ---------------------------------------------------------------
   // The wait state lets a read see a write done just before it.
   always_comb begin
      rd_ph_next = 1'b0;
      wr_ph_next = 1'b0;
      idx_next = idx_reg;
      hready_next = 1'b1;
      hrdata_next = hrdata_reg;
      if (rd_ph_reg) begin
         hrdata_next = 32'h0;
         case (idx_reg)
            IDX_DATA_LOW: hrdata_next[7:0] = data_low_reg;
            IDX_ADDR_LOW: hrdata_next[7:0] = addr_low_reg;
            IDX_DATA_HIGH: hrdata_next[5:0] = data_high_reg;
            IDX_ADDR_HIGH: hrdata_next[4:0] = addr_high_reg;
            IDX_FLAGS: hrdata_next[FLAG_DONE] = done_reg;
            IDX_CTRL: begin
               hrdata_next[CTL_PSEL] = psel_reg;
               hrdata_next[CTL_ABORT] = abort_reg;
               hrdata_next[CTL_PERMIT] = permit_reg;
               hrdata_next[CTL_WGO] = wgo_reg;
               hrdata_next[CTL_RGO] = rgo_reg;
            end
            default: hrdata_next = 32'h0;
         endcase
      end else if (hsel && htrans[1] && hready) begin
         rd_ph_next = !hwrite;
         wr_ph_next = hwrite;
         hready_next = hwrite;
         idx_next = (haddr[31:12] == 20'h0) ? haddr[11:2] : IDX_NONE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_ph_reg <= 1'b0;
         wr_ph_reg <= 1'b0;
         idx_reg <= IDX_NONE;
         hready_reg <= 1'b1;
         hrdata_reg <= 32'h0;
      end else begin
         rd_ph_reg <= rd_ph_next;
         wr_ph_reg <= wr_ph_next;
         idx_reg <= idx_next;
         hready_reg <= hready_next;
         hrdata_reg <= hrdata_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hready_reg;
   assign hresp = 1'b0;

   // ---------------------------------------------------------------
   // Reset source and strap synchronisers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_reg <= 4'h0;
         sync2_reg <= 4'h0;
      end else begin
         sync1_reg <= {code_protect, bor_reset_in, wdt_reset_in,
                       ext_reset_in};
         sync2_reg <= sync1_reg;
      end
   end

   // ---------------------------------------------------------------
   // Controller
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      psel_next = psel_reg;
      abort_next = abort_reg;
      permit_next = permit_reg;
      wgo_next = wgo_reg;
      rgo_next = rgo_reg;
      done_next = done_reg;
      data_low_next = data_low_reg;
      addr_low_next = addr_low_reg;
      data_high_next = data_high_reg;
      addr_high_next = addr_high_reg;
      unlock_next = unlock_reg;
      cnt_next = cnt_reg;
      prog_addr_next = prog_addr_reg;
      prog_rd_next = prog_rd_reg;
      prog_en_next = !sync2_reg[3];
      mif.wr_en = 1'b0;
      mif.rd_en = 1'b0;
      mif.addr = addr_low_reg;
      mif.wdata = data_low_reg;
      // Software writes; go bits are only ever set here
      if (wr_ph_reg) begin
         unlock_next = UNL_IDLE;
         case (idx_reg)
            IDX_DATA_LOW: data_low_next = wd;
            IDX_ADDR_LOW: addr_low_next = wd;
            IDX_DATA_HIGH: data_high_next = wd[5:0];
            IDX_ADDR_HIGH: addr_high_next = wd[4:0];
            IDX_FLAGS: done_next = wd[FLAG_DONE];
            IDX_UNLOCK: begin
               if (wd == UNLOCK_KEY1) begin
                  unlock_next = UNL_ONE;
               end else if (wd == UNLOCK_KEY2 && unlock_reg == UNL_ONE) begin
                  unlock_next = UNL_TWO;
               end
            end
            IDX_CTRL: begin
               psel_next = wd[CTL_PSEL];
               permit_next = wd[CTL_PERMIT];
               abort_next = wd[CTL_ABORT];
               if (state_reg == S_IDLE) begin
                  if (wd[CTL_RGO]) begin
                     rgo_next = 1'b1;
                     if (!wd[CTL_PSEL]) begin
                        mif.rd_en = 1'b1;
                        state_next = S_DRD;
                     end else begin
                        prog_addr_next = {addr_high_reg, addr_low_reg};
                        if (!BIG_PROG) begin
                           prog_addr_next &= PROG_MASK_4K;
                        end
                        prog_rd_next = 1'b1;
                        state_next = S_PRD1;
                     end
                  end else if (wd[CTL_WGO] && !wd[CTL_PSEL] && permit_reg
                               && unlock_reg == UNL_TWO) begin
                     wgo_next = 1'b1;
                     cnt_next = 18'h0;
                     state_next = S_WER;
                  end
               end
            end
            default: ;
         endcase
      end
      // Hardware sequencing; its sets land after software's clears
      case (state_reg)
         S_IDLE: ;
         S_DRD: begin
            data_low_next = mif.rdata;
            rgo_next = 1'b0;
            state_next = S_IDLE;
         end
         S_PRD1: begin
            prog_rd_next = 1'b0;
            state_next = S_PRD2;
         end
         S_PRD2: begin
            data_low_next = prog_rdata[7:0];
            data_high_next = prog_rdata[13:8];
            rgo_next = 1'b0;
            state_next = S_IDLE;
         end
         S_WER: begin
            cnt_next = cnt_reg + 18'h1;
            if (cnt_reg == erase_cyc - 18'h1) begin
               mif.wr_en = 1'b1;
               mif.wdata = ERASED_BYTE;
               cnt_next = 18'h0;
               state_next = S_WPR;
            end
         end
         S_WPR: begin
            cnt_next = cnt_reg + 18'h1;
            if (cnt_reg == WR_CYCLES - erase_cyc - 18'h1) begin
               mif.wr_en = 1'b1;
               wgo_next = 1'b0;
               done_next = 1'b1;
               abort_next = 1'b0;
               state_next = S_IDLE;
            end
         end
         default: state_next = S_IDLE;
      endcase
      // Abort resets clear control bits other than abort, and keep data low and address, bar a same-cycle bus write; S_PRD2 still loads data high
      if (abort_rst) begin
         if (busy_wr) begin
            abort_next = 1'b1;
         end
         mif.wr_en = 1'b0;
         data_low_next = wr_ph_reg ? data_low_next : data_low_reg;
         psel_next = 1'b0;
         permit_next = 1'b0;
         wgo_next = 1'b0;
         rgo_next = 1'b0;
         prog_rd_next = 1'b0;
         unlock_next = UNL_IDLE;
         state_next = S_IDLE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= S_IDLE;
         psel_reg <= 1'b0;
         abort_reg <= 1'b0;
         permit_reg <= 1'b0;
         wgo_reg <= 1'b0;
         rgo_reg <= 1'b0;
         done_reg <= 1'b0;
         data_low_reg <= 8'h00;
         addr_low_reg <= 8'h00;
         data_high_reg <= 6'h00;
         addr_high_reg <= 5'h00;
         unlock_reg <= UNL_IDLE;
         cnt_reg <= 18'h0;
         prog_addr_reg <= 13'h0;
         prog_rd_reg <= 1'b0;
         prog_en_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         psel_reg <= psel_next;
         abort_reg <= abort_next;
         permit_reg <= permit_next;
         wgo_reg <= wgo_next;
         rgo_reg <= rgo_next;
         done_reg <= done_next;
         data_low_reg <= data_low_next;
         addr_low_reg <= addr_low_next;
         data_high_reg <= data_high_next;
         addr_high_reg <= addr_high_next;
         unlock_reg <= unlock_next;
         cnt_reg <= cnt_next;
         prog_addr_reg <= prog_addr_next;
         prog_rd_reg <= prog_rd_next;
         prog_en_reg <= prog_en_next;
      end
   end

   assign prog_addr = prog_addr_reg;
   assign prog_rd = prog_rd_reg;
   assign programmer_en = prog_en_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   AST_DRD_NEXT: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == S_DRD && !abort_rst && !wr_ph_reg) |=>
      (data_low_reg == $past(mif.rdata)) && !rgo_reg)
      else $error("data read byte not loaded next cycle");
   AST_PRD_SLOT: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == S_IDLE && state_next == S_PRD1) |=>
      prog_rd_reg ##1 (!prog_rd_reg && state_reg == S_PRD2))
      else $error("program read slot wrong");
   AST_WGO_KEY: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wgo_reg) |-> $past(unlock_reg) == UNL_TWO)
      else $error("write started without unlock sequence");
   AST_WGO_PERMIT: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wgo_reg) |-> $past(permit_reg))
      else $error("write started without permit");
   AST_WGO_DATA: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(wgo_reg) |-> !psel_reg && state_reg == S_WER)
      else $error("write started in program space");
   AST_ERASE_FIRST: assert property (@(posedge hclk) disable iff (!hresetn)
      (mif.wr_en && state_reg == S_WER) |->
      mif.wdata == ERASED_BYTE ##1 state_reg == S_WPR)
      else $error("erase step missing");
   AST_DONE_SET: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == S_WPR && state_next == S_IDLE && !abort_rst) |->
      cnt_reg == WR_CYCLES - erase_cyc - 18'h1
      ##1 done_reg && !wgo_reg && !abort_reg)
      else $error("write end not flagged");
   AST_ABORT: assert property (@(posedge hclk) disable iff (!hresetn)
      (abort_rst && busy_wr) |=>
      abort_reg && !wgo_reg && state_reg == S_IDLE)
      else $error("aborted write not flagged");
   AST_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
      (abort_rst && !wr_ph_reg) |=>
      $stable(addr_low_reg) && $stable(data_low_reg))
      else $error("abort reset changed data or address");
   AST_UNLOCK_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      (rd_ph_reg && idx_reg == IDX_UNLOCK) |=> hrdata_reg == 32'h0)
      else $error("unlock port read not zero");
endmodule

/* File: verif/tb_niac_top.sv */
`timescale 1ns/1ps
module tb_niac_top
   import niac_pkg::*;
;
   // ---------------------------------------------------------------
   // Signals and design
   // ---------------------------------------------------------------
   logic hclk;
   logic hresetn;
   logic hsel;
   logic hwrite;
   logic hreadyout;
   logic prog_rd;
   logic programmer_en;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [12:0] prog_addr;
   logic [13:0] prog_rdata;
   logic ext_rst;
   logic wdt_rst;
   logic bor_rst;
   logic code_protect;
   int num_errors;
   int checked;
   int cycles;
   logic [9:0] reg_idx [8];
   logic [7:0] reg_mask [4];

   niac_top #(.WR_CYCLES(18'h14), .BIG_PROG(1'h1)) niac_top_i (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .prog_addr(prog_addr),
      .prog_rd(prog_rd), .prog_rdata(prog_rdata),
      .ext_reset_in(ext_rst), .wdt_reset_in(wdt_rst),
      .bor_reset_in(bor_rst), .code_protect(code_protect),
      .programmer_en(programmer_en)
   );

   initial begin
      hclk = 1'h0;
      forever #12.5 hclk = ~hclk;
   end

   // Program array stand-in: word valid the cycle after the strobe
   always @(posedge hclk) begin
      if (prog_rd === 1'h1) begin
         prog_rdata <= {1'h1, prog_addr} ^ 14'h2C3A;
      end
   end

   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         close_out();
      end
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t: %s seen %h expected %h", $time, what, seen,
                  exp);
      end
   endtask

   task automatic bus_xfer(input logic [9:0] idx, input logic wr,
                           input logic [7:0] d, output logic [31:0] q);
      @(posedge hclk);
      haddr <= {20'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask

   task automatic bus_write(input logic [9:0] idx, input logic [7:0] d);
      logic [31:0] q;
      bus_xfer(idx, 1'h1, d, q);
   endtask

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
      logic [31:0] q;
      bus_xfer(idx, 1'h0, 8'h00, q);
      check(q, {24'h0, exp}, $sformatf("register %h", idx));
   endtask

   task automatic start_write(input logic [7:0] a, input logic [7:0] d);
      bus_write(IDX_ADDR_LOW, a);
      bus_write(IDX_DATA_LOW, d);
      bus_write(IDX_CTRL, 8'h04);
      bus_write(IDX_UNLOCK, UNLOCK_KEY1);
      bus_write(IDX_UNLOCK, UNLOCK_KEY2);
      bus_write(IDX_CTRL, 8'h06);
   endtask

   task automatic wait_write();
      logic [31:0] q;
      int n;
      q = 32'h2;
      n = 0;
      while (q[1] !== 1'h0 && n < 100) begin
         bus_xfer(IDX_CTRL, 1'h0, 8'h00, q);
         n++;
      end
      check({31'h0, q[1]}, 32'h0, "write go still set");
   endtask

   task automatic prog_chk(input logic [12:0] a);
      logic [13:0] w;
      w = {1'h1, a} ^ 14'h2C3A;
      bus_write(IDX_ADDR_HIGH, {3'h0, a[12:8]});
      bus_write(IDX_ADDR_LOW, a[7:0]);
      bus_write(IDX_CTRL, 8'h81);
      rd_chk(IDX_DATA_LOW, w[7:0]);
      rd_chk(IDX_DATA_HIGH, {2'h0, w[13:8]});
      rd_chk(IDX_CTRL, 8'h80);
      check({19'h0, prog_addr}, {19'h0, a}, "program address");
   endtask

   task automatic end_test(input string name);
      $display("test %s done, errors so far %0d", name, num_errors);
   endtask

   task automatic close_out();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'h0;
      hsel = 1'h1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      prog_rdata = 14'h0;
      ext_rst = 1'h0;
      wdt_rst = 1'h0;
      bor_rst = 1'h0;
      code_protect = 1'h0;
      num_errors = 0;
      checked = 0;
      cycles = 0;
      reg_idx = '{IDX_DATA_LOW, IDX_ADDR_LOW, IDX_DATA_HIGH, IDX_ADDR_HIGH,
                  IDX_CTRL, IDX_FLAGS, IDX_UNLOCK, 10'h200};
      reg_mask = '{8'hFF, 8'hFF, 8'h3F, 8'h1F};
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      // Reset values, unlock port and an unmapped word read zero
      foreach (reg_idx[i]) rd_chk(reg_idx[i], 8'h00);
      end_test("reset");
      foreach (reg_mask[i]) begin
         bus_write(reg_idx[i], 8'hFF);
         rd_chk(reg_idx[i], reg_mask[i]);
      end
      bus_write(IDX_UNLOCK, UNLOCK_KEY1);
      rd_chk(IDX_UNLOCK, 8'h00);
      end_test("masks");
      // Top of the 8k space, then an ordinary word
      prog_chk(13'h1FFF);
      prog_chk(13'h0A5C);
      bus_write(IDX_CTRL, 8'h84);
      bus_write(IDX_UNLOCK, UNLOCK_KEY1);
      bus_write(IDX_UNLOCK, UNLOCK_KEY2);
      bus_write(IDX_CTRL, 8'h86);
      rd_chk(IDX_CTRL, 8'h84);
      end_test("program");
      // Unlock keys split by another write, then permit given in the same write
      bus_write(IDX_CTRL, 8'h04);
      bus_write(IDX_UNLOCK, UNLOCK_KEY1);
      bus_write(IDX_ADDR_LOW, 8'h33);
      bus_write(IDX_UNLOCK, UNLOCK_KEY2);
      bus_write(IDX_CTRL, 8'h06);
      rd_chk(IDX_CTRL, 8'h04);
      bus_write(IDX_CTRL, 8'h00);
      bus_write(IDX_UNLOCK, UNLOCK_KEY1);
      bus_write(IDX_UNLOCK, UNLOCK_KEY2);
      bus_write(IDX_CTRL, 8'h06);
      rd_chk(IDX_CTRL, 8'h04);
      rd_chk(IDX_FLAGS, 8'h00);
      end_test("refused");
      // Each reset source cuts a running write short
      for (int i = 0; i < 3; i++) begin
         start_write(8'h40 + 8'(i), 8'hC3);
         @(posedge hclk);
         {bor_rst, wdt_rst, ext_rst} <= 3'h1 << i;
         repeat (6) @(posedge hclk);
         {bor_rst, wdt_rst, ext_rst} <= 3'h0;
         repeat (4) @(posedge hclk);
         rd_chk(IDX_CTRL, 8'h08);
         rd_chk(IDX_ADDR_LOW, 8'h40 + 8'(i));
         rd_chk(IDX_DATA_LOW, 8'hC3);
         rd_chk(IDX_FLAGS, 8'h00);
      end
      end_test("abort");
      // Full write at the last address; permit dropped mid-write
      start_write(8'hFF, 8'h5A);
      rd_chk(IDX_CTRL, 8'h06);
      bus_write(IDX_CTRL, 8'h01);
      rd_chk(IDX_CTRL, 8'h02);
      wait_write();
      rd_chk(IDX_FLAGS, 8'h80);
      rd_chk(IDX_CTRL, 8'h00);
      bus_write(IDX_DATA_LOW, 8'h00);
      bus_write(IDX_CTRL, 8'h01);
      rd_chk(IDX_DATA_LOW, 8'h5A);
      rd_chk(IDX_CTRL, 8'h00);
      rd_chk(IDX_FLAGS, 8'h80);
      bus_write(IDX_FLAGS, 8'h00);
      rd_chk(IDX_FLAGS, 8'h00);
      end_test("write");
      // Protection strap only gates the external programmer
      code_protect <= 1'h1;
      repeat (6) @(posedge hclk);
      check({31'h0, programmer_en}, 32'h0, "programmer gate");
      rd_chk(IDX_DATA_LOW, 8'h5A);
      code_protect <= 1'h0;
      repeat (6) @(posedge hclk);
      check({31'h0, programmer_en}, 32'h1, "programmer gate");
      end_test("protect");
      close_out();
   end
endmodule
